// *** inc/ccrs_map.vh ***
// Register map, field positions and reset values of the CPU context block.
`ifndef CCRS_MAP_VH
`define CCRS_MAP_VH
// Register word offsets on the AHB-Lite bus (byte addresses).
`define CCRS_ACC_OFS 12'h000
`define CCRS_XIDX_OFS 12'h004
`define CCRS_YIDX_OFS 12'h008
`define CCRS_NIA_OFS 12'h00c
`define CCRS_SP_OFS 12'h010
`define CCRS_FLAGS_OFS 12'h014
`define CCRS_CMD_OFS 12'h018
`define CCRS_IRQ_OFS 12'h01c
`define CCRS_STAT_OFS 12'h020
`define CCRS_ALU_OFS 12'h024
// Stack window limits and forced upper bits of the stack pointer.
`define CCRS_SP_TOP 16'h017f
`define CCRS_SP_BOT 16'h0140
`define CCRS_SP_HIGH 10'h005
// Pointer offset within the window that marks the top of the stack.
`define CCRS_SP_TOP_OFS 6'h3f
// Condition flag bit positions.
`define CCRS_F_C 0
`define CCRS_F_Z 1
`define CCRS_F_N 2
`define CCRS_F_I 3
`define CCRS_F_H 4
// Command register bit positions.
`define CCRS_CMD_PUSH 0
`define CCRS_CMD_POP 1
`define CCRS_CMD_CALL 2
`define CCRS_CMD_RET 3
`define CCRS_CMD_IRET 4
`define CCRS_CMD_RSP 5
`define CCRS_CMD_TRAP 6
`define CCRS_CMD_PRE 7
// Stack sequence kinds, sized to the sequencer's kind register.
`define CCRS_KIND_PUSH 3'h0
`define CCRS_KIND_POP 3'h1
`define CCRS_KIND_CALL 3'h2
`define CCRS_KIND_RET 3'h3
`define CCRS_KIND_IRET 3'h4
// ALU operation codes in the ALU register, bits 10:8.
`define CCRS_OP_LOAD 3'h0
`define CCRS_OP_ADD 3'h1
`define CCRS_OP_ADC 3'h2
`define CCRS_OP_SUB 3'h3
`define CCRS_OP_AND 3'h4
`define CCRS_OP_SHL 3'h5
`define CCRS_OP_TEST 3'h6
// Reset values.
`define CCRS_FLAGS_RST 5'h08
`define CCRS_BYTE_RST 8'h00
`define CCRS_NIA_RST 16'h0000
`endif

// *** hw/ccrs_top.v ***
// CPU programming-model registers with hardware context stack.
//
// What this block does
// RULE_01 - One 8-bit accumulator for ALU operands/results.
// RULE_02 - Two 8-bit index registers.
// RULE_03 - Prefix selects second index register.
// RULE_04 - 16-bit next instruction address register.
// RULE_05 - Stack pointer confined to 0x0140-0x017F.
// RULE_06 - Reset and rewind load stack top.
// RULE_07 - Push writes then decrements; pop increments first.
// RULE_08 - Push below bottom wraps silently to top.
// RULE_09 - Interrupt saves all registers except Y and the stack pointer.
// RULE_10 - Return address low byte saved first.
// RULE_11 - Return restores in reverse save order.
// RULE_12 - Call uses two bytes, interrupt five.
// RULE_13 - Five-bit condition flags, individually readable.
// RULE_14 - Nibble carry set on add carry 3-4.
// RULE_15 - Mask blocks all interrupts except trap.
// RULE_16 - Masked requests latched, one per source.
// RULE_17 - Sign flag follows result MSB.
// RULE_18 - Null flag set on zero result.
// RULE_19 - Spill flag on carry, borrow, shifts.
// RULE_20 - Mask set after save, restored on return.
`timescale 1ns/100ps
`include "ccrs_map.vh"

module ccrs_top #(
   parameter NIRQ = 4
)(
   input wire core_clk,
   input wire resetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [NIRQ-1:0] irqReq,
   output reg [15:0] stackAddr,
   output reg [7:0] stackWrData,
   output reg stackWe,
   output reg stackRe,
   input wire [7:0] stackRdData,
   output reg busy
);

   ////////////////////////////////////////////////////////////////////
   // Reset release and state declarations.

   // Reset synchroniser; the first stage feeds only the second.
   reg rstMeta;
   reg rstSync;
   wire rstN = rstSync;

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // Sequencer states.
   localparam S_IDLE = 3'd0;
   localparam S_WR = 3'd1;
   localparam S_RD = 3'd2;
   localparam S_RDW = 3'd3;
   localparam S_DONE = 3'd4;

   reg [7:0] acc_reg;            // Accumulator.
   reg [7:0] xIdx_reg;           // First index register.
   reg [7:0] yIdx_reg;           // Second index register.
   reg [15:0] nextInstrAddr_reg; // Next instruction address.
   reg [5:0] spOff_reg;          // Stack pointer low six bits.
   reg [4:0] condFlags_reg;      // Condition flags.
   reg prefix_reg;               // Prefix pending for next ALU op.
   reg [NIRQ-1:0] pend_reg;      // Latched interrupt requests.
   reg [2:0] state_reg;          // Sequencer state.
   reg [2:0] cnt_reg;            // Step of a sequence; selects the saved or restored byte.
   reg [2:0] kind_reg;           // Sequence kind (command bit index).
   reg [7:0] pushByte_reg;       // Byte for single push.
   reg [3:0] irqNum_reg;         // Vector index of the serviced request.
   reg wrPend_reg;               // Data phase of a write pending.
   reg [11:0] wrAddr_reg;        // Address captured for that write.

   // Full stack pointer with upper bits forced. [RULE_05]
   wire [15:0] spFull = {`CCRS_SP_HIGH, spOff_reg};

   ////////////////////////////////////////////////////////////////////
   // Bus decode.

   // A valid address phase selected to this slave.
   wire addrValid = hsel & hready & htrans[1];

   // Write-data strobes decoded from the captured address.
   wire wAcc = wrPend_reg & (wrAddr_reg == `CCRS_ACC_OFS);
   wire wX = wrPend_reg & (wrAddr_reg == `CCRS_XIDX_OFS);
   wire wY = wrPend_reg & (wrAddr_reg == `CCRS_YIDX_OFS);
   wire wNia = wrPend_reg & (wrAddr_reg == `CCRS_NIA_OFS);
   wire wFlags = wrPend_reg & (wrAddr_reg == `CCRS_FLAGS_OFS);
   wire wCmd = wrPend_reg & (wrAddr_reg == `CCRS_CMD_OFS);
   wire wAlu = wrPend_reg & (wrAddr_reg == `CCRS_ALU_OFS);

   // Commands are ignored while a stack sequence runs.
   wire cmdOk = wCmd & (state_reg == S_IDLE);

   ////////////////////////////////////////////////////////////////////
   // Interrupt arbitration.

   // Lowest-numbered pending request is chosen.
   reg [3:0] irqSel;
   reg irqAny;
   integer i;
   always @*
   begin
      irqSel = 4'h0;
      irqAny = 1'b0;
      for (i = NIRQ - 1; i >= 0; i = i - 1)
      begin
         if (pend_reg[i])
         begin
            irqSel = i[3:0];
            irqAny = 1'b1;
         end
      end
   end

   // Masked requests stay pending; a trap bypasses the mask. [RULE_15]
   wire trapTake = cmdOk & hwdata[`CCRS_CMD_TRAP];
   wire irqTake = (state_reg == S_IDLE) & irqAny & ~wCmd &
                  ~condFlags_reg[`CCRS_F_I];

   ////////////////////////////////////////////////////////////////////
   // ALU used by register-bus operations.

   // Operand comes from X, or Y when the prefix is pending. [RULE_03]
   wire [7:0] opB = prefix_reg ? yIdx_reg : xIdx_reg;
   wire [2:0] aluOp = hwdata[10:8];
   wire [7:0] aluImm = hwdata[7:0];

   // Result and flag updates. [RULE_01]
   reg [8:0] aluRes;
   reg [4:0] aluFlags;
   always @*
   begin
      aluRes = {1'b0, acc_reg};
      aluFlags = condFlags_reg;
      case (aluOp)
         `CCRS_OP_LOAD: aluRes = {1'b0, aluImm};
         `CCRS_OP_ADD: aluRes = {1'b0, acc_reg} + {1'b0, opB};
         `CCRS_OP_ADC: aluRes = {1'b0, acc_reg} + {1'b0, opB} +
                               {8'h00, condFlags_reg[`CCRS_F_C]};
         `CCRS_OP_SUB: aluRes = {1'b0, acc_reg} - {1'b0, opB};
         `CCRS_OP_AND: aluRes = {1'b0, acc_reg & opB};
         `CCRS_OP_SHL: aluRes = {acc_reg, 1'b0};
         `CCRS_OP_TEST: aluRes = {1'b0, acc_reg & opB};
         default: aluRes = {1'b0, acc_reg};
      endcase
      // Nibble carry only for the two add forms. [RULE_14]
      if (aluOp == `CCRS_OP_ADD || aluOp == `CCRS_OP_ADC)
         aluFlags[`CCRS_F_H] = ({1'b0, acc_reg[3:0]} + {1'b0, opB[3:0]} +
            ((aluOp == `CCRS_OP_ADC) ? {4'h0, condFlags_reg[`CCRS_F_C]} :
            5'h00)) > 5'h0f;
      aluFlags[`CCRS_F_N] = aluRes[7];              // [RULE_17]
      aluFlags[`CCRS_F_Z] = (aluRes[7:0] == 8'h00); // [RULE_18]
      // Carry/borrow out; shift and test also drive it. [RULE_19]
      if (aluOp != `CCRS_OP_LOAD && aluOp != `CCRS_OP_AND)
         aluFlags[`CCRS_F_C] = (aluOp == `CCRS_OP_TEST) ?
            (aluRes[7:0] != 8'h00) : aluRes[8];
   end

   ////////////////////////////////////////////////////////////////////
   // Bus slave response and write capture.

   // Zero-wait-state slave; always OKAY; read data decoded at address.
   always @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 12'h000;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend_reg <= addrValid & hwrite;
         wrAddr_reg <= haddr[11:0];
         if (addrValid & ~hwrite)
         begin
            if (haddr[11:0] == `CCRS_ACC_OFS)
               hrdata <= {24'h000000, acc_reg};
            else if (haddr[11:0] == `CCRS_XIDX_OFS)
               hrdata <= {24'h000000, xIdx_reg};
            else if (haddr[11:0] == `CCRS_YIDX_OFS)
               hrdata <= {24'h000000, yIdx_reg};
            else if (haddr[11:0] == `CCRS_NIA_OFS)
               hrdata <= {16'h0000, nextInstrAddr_reg};
            else if (haddr[11:0] == `CCRS_SP_OFS)
               hrdata <= {16'h0000, spFull};
            else if (haddr[11:0] == `CCRS_FLAGS_OFS)
               hrdata <= {27'h0000000, condFlags_reg}; // [RULE_13]
            else if (haddr[11:0] == `CCRS_IRQ_OFS)
               hrdata <= {{(32-NIRQ){1'b0}}, pend_reg};
            else if (haddr[11:0] == `CCRS_STAT_OFS)
               hrdata <= {26'h0000000, prefix_reg, irqNum_reg,
                          state_reg != S_IDLE};
            else
               hrdata <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt request latch.

   // One pending bit per source; new request wins over clear. [RULE_16]
   always @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
         pend_reg <= {NIRQ{1'b0}};
      else
         pend_reg <= (pend_reg & ~(irqTake ? ({{(NIRQ-1){1'b0}}, 1'b1}
                     << irqSel) : {NIRQ{1'b0}})) | irqReq;
   end

   ////////////////////////////////////////////////////////////////////
   // Context stack sequencer and programming-model registers.

   // Byte written at a given save step: RETURN_ADDRESS_LOW, PCH, X, A, flags. [RULE_10]
   reg [7:0] saveByte;
   always @*
   begin
      case (cnt_reg)
         3'd5: saveByte = nextInstrAddr_reg[7:0];
         3'd4: saveByte = nextInstrAddr_reg[15:8];
         3'd3: saveByte = xIdx_reg;
         3'd2: saveByte = acc_reg;
         default: saveByte = {3'h0, condFlags_reg};
      endcase
   end

   // Main sequencer and register updates.
   always @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         acc_reg <= `CCRS_BYTE_RST;
         xIdx_reg <= `CCRS_BYTE_RST;
         yIdx_reg <= `CCRS_BYTE_RST;
         nextInstrAddr_reg <= `CCRS_NIA_RST;
         spOff_reg <= `CCRS_SP_TOP_OFS;      // [RULE_06]
         condFlags_reg <= `CCRS_FLAGS_RST;
         prefix_reg <= 1'b0;
         state_reg <= S_IDLE;
         cnt_reg <= 3'd0;
         kind_reg <= 3'd0;
         pushByte_reg <= 8'h00;
         irqNum_reg <= 4'h0;
         stackAddr <= `CCRS_SP_TOP;
         stackWrData <= 8'h00;
         stackWe <= 1'b0;
         stackRe <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         stackWe <= 1'b0;
         stackRe <= 1'b0;
         case (state_reg)
            S_IDLE:
            begin
               if (wAcc)
                  acc_reg <= hwdata[7:0];
               if (wX)
                  xIdx_reg <= hwdata[7:0];    // [RULE_02]
               if (wY)
                  yIdx_reg <= hwdata[7:0];
               if (wNia)
                  nextInstrAddr_reg <= hwdata[15:0]; // [RULE_04]
               if (wFlags)
                  condFlags_reg <= hwdata[4:0];
               if (wAlu)
               begin
                  if (aluOp != `CCRS_OP_TEST)
                     acc_reg <= aluRes[7:0];
                  condFlags_reg <= aluFlags;
                  prefix_reg <= 1'b0;
               end
               if (cmdOk & hwdata[`CCRS_CMD_PRE])
                  prefix_reg <= 1'b1;         // [RULE_03]
               if (cmdOk & hwdata[`CCRS_CMD_RSP])
                  spOff_reg <= `CCRS_SP_TOP_OFS; // [RULE_06]
               if (trapTake | irqTake)
               begin
                  // Five bytes, Y excluded. [RULE_09] [RULE_12]
                  kind_reg <= `CCRS_KIND_IRET;
                  cnt_reg <= 3'd5;
                  irqNum_reg <= trapTake ? 4'hf : irqSel;
                  state_reg <= S_WR;
                  busy <= 1'b1;
               end
               else if (cmdOk & hwdata[`CCRS_CMD_CALL])
               begin
                  kind_reg <= `CCRS_KIND_CALL; // [RULE_12]
                  cnt_reg <= 3'd5;
                  state_reg <= S_WR;
                  busy <= 1'b1;
               end
               else if (cmdOk & hwdata[`CCRS_CMD_PUSH])
               begin
                  kind_reg <= `CCRS_KIND_PUSH;
                  pushByte_reg <= hwdata[23:16];
                  cnt_reg <= 3'd1;
                  state_reg <= S_WR;
                  busy <= 1'b1;
               end
               else if (cmdOk & (hwdata[`CCRS_CMD_IRET] |
                        hwdata[`CCRS_CMD_RET] | hwdata[`CCRS_CMD_POP]))
               begin
                  kind_reg <= hwdata[`CCRS_CMD_IRET] ? `CCRS_KIND_IRET :
                     (hwdata[`CCRS_CMD_RET] ? `CCRS_KIND_RET :
                     `CCRS_KIND_POP);
                  // Reverse order: flags first on interrupt return. [RULE_11]
                  cnt_reg <= hwdata[`CCRS_CMD_IRET] ? 3'd1 :
                     (hwdata[`CCRS_CMD_RET] ? 3'd4 : 3'd0);
                  state_reg <= S_RD;
                  busy <= 1'b1;
               end
            end
            S_WR:
            begin
               // Write at pointer, then decrement with wrap. [RULE_07]
               stackAddr <= spFull;
               stackWrData <= (kind_reg == `CCRS_CMD_PUSH) ?
                  pushByte_reg : saveByte;
               stackWe <= 1'b1;
               spOff_reg <= spOff_reg - 6'd1; // [RULE_08]
               if (cnt_reg == 3'd1 || (kind_reg == `CCRS_CMD_CALL &&
                   cnt_reg == 3'd4))
               begin
                  state_reg <= S_DONE;
                  if (kind_reg == `CCRS_CMD_IRET)
                     condFlags_reg[`CCRS_F_I] <= 1'b1; // [RULE_20]
               end
               else
                  cnt_reg <= cnt_reg - 3'd1;
            end
            S_RD:
            begin
               // Increment first, then read. [RULE_07]
               spOff_reg <= spOff_reg + 6'd1;
               stackAddr <= {`CCRS_SP_HIGH, spOff_reg + 6'd1};
               stackRe <= 1'b1;
               state_reg <= S_RDW;
            end
            S_RDW:
            begin
               case (cnt_reg)
                  3'd1: condFlags_reg <= stackRdData[4:0]; // [RULE_20]
                  3'd2: acc_reg <= stackRdData;
                  3'd3: xIdx_reg <= stackRdData;
                  3'd4: nextInstrAddr_reg[15:8] <= stackRdData;
                  3'd5: nextInstrAddr_reg[7:0] <= stackRdData;
                  default: acc_reg <= stackRdData;
               endcase
               if (cnt_reg == 3'd5 || cnt_reg == 3'd0)
                  state_reg <= S_DONE;
               else
               begin
                  cnt_reg <= cnt_reg + 3'd1;
                  state_reg <= S_RD;
               end
            end
            default:
            begin
               busy <= 1'b0;
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// *** verif/ccrs_stack_ram.sv ***
// Behavioural model of the RAM stack window beside the context block.
`timescale 1ns/100ps
module ccrs_stack_ram (
   input wire logic core_clk,
   input wire logic [15:0] stackAddr,
   input wire logic [7:0] stackWrData,
   input wire logic stackWe,
   input wire logic stackRe,
   output logic [7:0] stackRdData
);
   // One byte per location of the 64-byte window.
   logic [7:0] mem [0:63];
   // Writes land at the edge that samples the write strobe.
   always @(posedge core_clk)
   begin
      if (stackWe)
         mem[stackAddr[5:0]] <= stackWrData;
   end
   // The block captures at the edge that ends its read strobe, so the array
   // answers at once; outside a read the inverse shows, so a late capture
   // picks up a wrong byte.
   assign stackRdData = stackRe ? mem[stackAddr[5:0]] :
      ~mem[stackAddr[5:0]];
endmodule

// *** verif/ccrs_top_asserts.sv ***
// Stack-side checks for the CPU context block.
`timescale 1ns/100ps
`include "ccrs_map.vh"
module ccrs_top_asserts (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [15:0] stackAddr,
   input wire logic stackWe,
   input wire logic stackRe,
   input wire logic busy
);
   // One clock domain, cleared by the pin reset.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Back-to-back writes, reads one gap apart, a five-write save.
   sequence wrTwo;
      stackWe ##1 stackWe;
   endsequence
   sequence rdTwo;
      stackRe ##1 !stackRe ##1 stackRe;
   endsequence
   sequence wrFive;
      stackWe [*5];
   endsequence
   stack_window_a: assert property (
      stackAddr[15:6] == `CCRS_SP_HIGH)
      else $error("Stack address out of window.");
   push_down_a: assert property (
      wrTwo |-> stackAddr[5:0] == $past(stackAddr[5:0]) - 6'h01)
      else $error("Write address did not step down.");
   pop_up_a: assert property (
      rdTwo |-> stackAddr[5:0] == $past(stackAddr[5:0], 2) + 6'h01)
      else $error("Read address did not step up.");
   save_five_a: assert property (
      wrFive |=> !stackWe)
      else $error("Write burst longer than five.");
   reset_top_a: assert property (
      $rose(resetn) |-> stackAddr == `CCRS_SP_TOP && !busy)
      else $error("Stack pointer not at top after reset.");
   strobe_busy_a: assert property (
      (stackWe || stackRe) |-> busy)
      else $error("Stack strobe outside a sequence.");
   strobe_excl_a: assert property (
      !(stackWe && stackRe))
      else $error("Read and write strobes together.");
   seq_end_a: assert property (
      $rose(busy) |-> ##[1:30] !busy)
      else $error("Stack sequence did not finish.");
endmodule
bind ccrs_top ccrs_top_asserts ccrs_top_asserts_i (.core_clk(core_clk),
   .resetn(resetn), .stackAddr(stackAddr), .stackWe(stackWe),
   .stackRe(stackRe), .busy(busy));

// *** verif/tb_cpu_context_registers_stack.sv ***
// Self-checking bench for the CPU context block and its RAM stack.
`timescale 1ns/100ps
`include "ccrs_map.vh"
module tb_cpu_context_registers_stack;
   // One ALU step: op, operand, expected ACC, flags and flag mask.
   typedef struct packed {
      logic [2:0] op;
      logic [7:0] x;
      logic [7:0] acc;
      logic [4:0] fl;
      logic [4:0] mask;
   } ccrs_row_t;
   ccrs_row_t rows [0:8];
   logic [7:0] save [0:4] = '{8'h34, 8'h12, 8'h03, 8'h08, 8'h00};
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] irqReq = 4'h0;
   logic [31:0] r;
   wire [31:0] hrdata;
   wire [15:0] stackAddr;
   wire [7:0] stackWrData, stackRdData;
   wire hreadyout, stackWe, stackRe, busy;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int i;
   ccrs_top ccrs_top_i (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .irqReq(irqReq),
      .stackAddr(stackAddr), .stackWrData(stackWrData), .stackWe(stackWe),
      .stackRe(stackRe), .stackRdData(stackRdData), .busy(busy));
   ccrs_stack_ram ccrs_stack_ram_i (.core_clk(core_clk),
      .stackAddr(stackAddr), .stackWrData(stackWrData), .stackWe(stackWe),
      .stackRe(stackRe), .stackRdData(stackRdData));
   // 50 MHz core clock.
   always #10 core_clk = ~core_clk;
   //////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("Mismatches %0d of %0d checks", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // One single AHB transfer; read data lands in r at the data-phase edge.
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   // Busy is polled so no command lands while a sequence runs.
   task automatic waitIdle();
      xfer(1'b0, `CCRS_STAT_OFS, 32'h0);
      while (r[0] !== 1'b0)
         xfer(1'b0, `CCRS_STAT_OFS, 32'h0);
   endtask
   task automatic cmd(input int n, input logic [7:0] b);
      wr(`CCRS_CMD_OFS, {8'h0, b, 8'h0, 8'h01 << n});
      repeat (2) @(posedge core_clk);
      waitIdle();
   endtask
   // Cuts a hang short.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         end_sim();
      end
   end
   //////////////////////////////////////////////////////////////
   initial
   begin
      rows[0] = '{`CCRS_OP_LOAD, 8'h00, 8'h00, 5'h02, 5'h06};
      rows[1] = '{`CCRS_OP_LOAD, 8'h8f, 8'h8f, 5'h04, 5'h06};
      rows[2] = '{`CCRS_OP_ADD, 8'h01, 8'h90, 5'h14, 5'h17};
      rows[3] = '{`CCRS_OP_ADD, 8'h70, 8'h00, 5'h03, 5'h17};
      rows[4] = '{`CCRS_OP_ADC, 8'h00, 8'h01, 5'h00, 5'h17};
      rows[5] = '{`CCRS_OP_SUB, 8'h02, 8'hff, 5'h05, 5'h07};
      rows[6] = '{`CCRS_OP_AND, 8'h0f, 8'h0f, 5'h00, 5'h06};
      rows[7] = '{`CCRS_OP_SHL, 8'h00, 8'h1e, 5'h00, 5'h07};
      rows[8] = '{`CCRS_OP_TEST, 8'h10, 8'h1e, 5'h00, 5'h06};
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      rdChk(`CCRS_FLAGS_OFS, 32'h08);
      rdChk(12'h03c, 32'h0);
      // ALU table: operand in X, result and masked flags compared.
      for (i = 0; i < 9; i++)
      begin
         wr(`CCRS_XIDX_OFS, {24'h0, rows[i].x});
         wr(`CCRS_ALU_OFS, {21'h0, rows[i].op, rows[i].x});
         rdChk(`CCRS_ACC_OFS, rows[i].acc);
         xfer(1'b0, `CCRS_FLAGS_OFS, 32'h0);
         r = r & rows[i].mask;
         chk(r, rows[i].fl);
      end
      wr(`CCRS_NIA_OFS, 32'h1234);
      rdChk(`CCRS_NIA_OFS, 32'h1234);
      wr(`CCRS_YIDX_OFS, 32'h05);
      rdChk(`CCRS_YIDX_OFS, 32'h05);
      cmd(`CCRS_CMD_PUSH, 8'h3c);
      chk(ccrs_stack_ram_i.mem[63], 8'h3c);
      rdChk(`CCRS_SP_OFS, 32'h017e);
      cmd(`CCRS_CMD_POP, 8'h00);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      rdChk(`CCRS_ACC_OFS, 32'h3c);
      // Sixty-four pushes run the pointer round the window.
      for (i = 0; i < 64; i++)
         cmd(`CCRS_CMD_PUSH, i[7:0]);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      chk(ccrs_stack_ram_i.mem[0], 8'h3f);
      cmd(`CCRS_CMD_PUSH, 8'haa);
      chk(ccrs_stack_ram_i.mem[63], 8'haa);
      cmd(`CCRS_CMD_RSP, 8'h00);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      wr(`CCRS_XIDX_OFS, 32'h03);
      wr(`CCRS_ALU_OFS, {21'h0, `CCRS_OP_LOAD, 8'h00});
      cmd(`CCRS_CMD_PRE, 8'h00);
      wr(`CCRS_ALU_OFS, {21'h0, `CCRS_OP_ADD, 8'h00});
      rdChk(`CCRS_ACC_OFS, 32'h05);
      wr(`CCRS_ALU_OFS, {21'h0, `CCRS_OP_ADD, 8'h00});
      rdChk(`CCRS_ACC_OFS, 32'h08);
      cmd(`CCRS_CMD_CALL, 8'h00);
      chk(ccrs_stack_ram_i.mem[62], 8'h12);
      rdChk(`CCRS_SP_OFS, 32'h017d);
      wr(`CCRS_NIA_OFS, 32'h0);
      cmd(`CCRS_CMD_RET, 8'h00);
      rdChk(`CCRS_NIA_OFS, 32'h1234);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      // A request while masked waits, then is saved once unmasked.
      irqReq <= 4'h2;
      @(posedge core_clk);
      irqReq <= 4'h0;
      repeat (4) @(posedge core_clk);
      rdChk(`CCRS_IRQ_OFS, 32'h02);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      wr(`CCRS_FLAGS_OFS, 32'h00);
      repeat (6) @(posedge core_clk);
      waitIdle();
      for (i = 0; i < 5; i++)
         chk(ccrs_stack_ram_i.mem[63 - i], save[i]);
      rdChk(`CCRS_SP_OFS, 32'h017a);
      rdChk(`CCRS_FLAGS_OFS, 32'h08);
      rdChk(`CCRS_IRQ_OFS, 32'h00);
      rdChk(`CCRS_YIDX_OFS, 32'h05);
      wr(`CCRS_ACC_OFS, 32'h77);
      wr(`CCRS_XIDX_OFS, 32'h66);
      cmd(`CCRS_CMD_IRET, 8'h00);
      rdChk(`CCRS_ACC_OFS, 32'h08);
      rdChk(`CCRS_XIDX_OFS, 32'h03);
      rdChk(`CCRS_NIA_OFS, 32'h1234);
      rdChk(`CCRS_FLAGS_OFS, 32'h00);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      wr(`CCRS_FLAGS_OFS, 32'h08);
      cmd(`CCRS_CMD_TRAP, 8'h00);
      rdChk(`CCRS_SP_OFS, 32'h017a);
      // A reset in mid-run puts the pointer and the mask back.
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rdChk(`CCRS_SP_OFS, 32'h017f);
      rdChk(`CCRS_FLAGS_OFS, 32'h08);
      end_sim();
   end
endmodule
